// >>> src/acs_pkg.sv
// Shared definitions for the comparator status and control register bank.
// Assumes a byte-wide register port and three comparators, indexed 0..2
// for comparators 1..3.
package acs_pkg;

    // Register offsets on the byte-wide port
    localparam logic [7:0] ACS_OFF_STATUS = 8'h00;
    localparam logic [7:0] ACS_OFF_DIS0 = 8'h01;
    localparam logic [7:0] ACS_OFF_DIS1 = 8'h02;
    localparam logic [7:0] ACS_OFF_CTRL1 = 8'h03;
    localparam logic [7:0] ACS_OFF_CTRL2 = 8'h04;
    localparam logic [7:0] ACS_OFF_CTRL3 = 8'h05;
    localparam logic [7:0] ACS_OFF_IRQ_STAT = 8'h06;
    localparam logic [7:0] ACS_OFF_IRQ_CLR = 8'h07;
    localparam logic [7:0] ACS_OFF_IRQ_EN = 8'h08;

    // Reset values
    localparam logic [7:0] ACS_RST_BYTE = 8'h00;
    localparam logic [2:0] ACS_RST_TRIO = 3'h0;
    localparam logic [13:0] ACS_RST_PINS = 14'h0000;

    // Field positions
    localparam int ACS_STAT_FLAG_LSB = 5;
    localparam int ACS_STAT_LEVEL_LSB = 1;
    localparam int ACS_CTRL_IE_BIT = 6;
    localparam int ACS_CTRL_SENS_LSB = 4;
    localparam int ACS_CTRL_HYST_LSB = 0;
    localparam logic [7:0] ACS_CTRL_MASK = 8'h77;
    localparam logic [7:0] ACS_DIS1_MASK = 8'h3f;

    // Sensitivity codes
    localparam logic [1:0] ACS_SENS_TOGGLE = 2'h0;
    localparam logic [1:0] ACS_SENS_RSVD = 2'h1;
    localparam logic [1:0] ACS_SENS_FALL = 2'h2;
    localparam logic [1:0] ACS_SENS_RISE = 2'h3;

    // Hysteresis steps in millivolts
    localparam int ACS_HYST_SMALL_MV = 10;
    localparam int ACS_HYST_LARGE_MV = 25;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } acs_bus_req_t;

    // Decoded hysteresis drive for one comparator
    typedef struct packed {
        logic [2:0] code;
        logic pos_en;
        logic neg_en;
        logic large_step;
    } acs_hyst_t;

endpackage : acs_pkg

// >>> src/acs_status.sv
// Status, control and input-disable register bank for three comparators.
// Assumes comparator levels and pin inputs synchronous to ref_clk, and an
// interrupt controller that pulses a vector-taken strobe per comparator.
//
// What this block does
// - Hysteresis code: none, +10, -10, +-10, reserved, +25, -25, +-25 mV.
// - Status bits 7..5 hold flags 3..1, bits 3..1 levels; 4, 0 reserved.
// - A flag sets when its output makes the edge chosen by sensitivity.
// - Vector entry clears a flag only while its interrupt enable is set.
// - Writing one to a flag bit clears it, zero leaves it, whatever enable.
// - Each event flag is offered as a converter and DAC trigger.
// - Each level bit is the live comparator output and is read-only.
// - A set input-disable bit turns off a pin buffer and reads its pin zero.
// - Sensitivity 00 toggle, 01 reserved, 10 falling, 11 rising edge.
// - A set flag requests an interrupt only while its enable is set.
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps

module acs_status (
    input wire logic ref_clk,
    input wire logic reset,
    input wire acs_pkg::acs_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    input wire logic [2:0] cmp_level_in,
    input wire logic [2:0] cmp_vector_taken,
    output logic [2:0] cmp_irq_req,
    output logic [2:0] cmp_trigger,
    output acs_pkg::acs_hyst_t [2:0] hyst_drive,
    input wire logic [13:0] pin_raw,
    output logic [13:0] pin_read,
    output logic [13:0] pin_buf_off,
    output logic irq
);

    // Event detection and flags
    logic [2:0] flag_q;
    logic [2:0] flag_d;
    logic [2:0] level_prev_q;
    logic primed_q;
    logic [2:0] edge_evt;
    logic [2:0] wr_clr;
    logic [2:0] vec_clr;
    logic [2:0] ie_vec;

    // Register storage
    logic [7:0] ctrl_q [3];
    logic [7:0] dis0_q;
    logic [7:0] dis1_q;
    logic [13:0] dis_all;

    // Block interrupt
    logic [2:0] irq_stat_q;
    logic [2:0] irq_en_q;
    logic [2:0] irq_clr;

    // Register port decode and read path
    logic wr_status;
    logic wr_dis0;
    logic wr_dis1;
    logic [2:0] wr_ctrl;
    logic wr_irq_clr;
    logic wr_irq_en;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic [7:0] status_view;

    // Write strobe decode, one strobe per register except the read-only ACS_OFF_IRQ_STAT
    always_comb begin
        wr_status = 1'b0;
        wr_dis0 = 1'b0;
        wr_dis1 = 1'b0;
        wr_ctrl = 3'h0;
        wr_irq_clr = 1'b0;
        wr_irq_en = 1'b0;
        if (bus_req.wr) begin
            if (bus_req.addr == acs_pkg::ACS_OFF_STATUS) begin
                wr_status = 1'b1;
            end else if (bus_req.addr == acs_pkg::ACS_OFF_DIS0) begin
                wr_dis0 = 1'b1;
            end else if (bus_req.addr == acs_pkg::ACS_OFF_DIS1) begin
                wr_dis1 = 1'b1;
            end else if (bus_req.addr == acs_pkg::ACS_OFF_CTRL1) begin
                wr_ctrl[0] = 1'b1;
            end else if (bus_req.addr == acs_pkg::ACS_OFF_CTRL2) begin
                wr_ctrl[1] = 1'b1;
            end else if (bus_req.addr == acs_pkg::ACS_OFF_CTRL3) begin
                wr_ctrl[2] = 1'b1;
            end else if (bus_req.addr == acs_pkg::ACS_OFF_IRQ_CLR) begin
                wr_irq_clr = 1'b1;
            end else if (bus_req.addr == acs_pkg::ACS_OFF_IRQ_EN) begin
                wr_irq_en = 1'b1;
            end
        end
    end

    // Interrupt enable per comparator
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            ie_vec[i] = ctrl_q[i][acs_pkg::ACS_CTRL_IE_BIT];
        end
    end

    // Previous level, for edge detection
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            level_prev_q <= acs_pkg::ACS_RST_TRIO;
        end else begin
            level_prev_q <= cmp_level_in;
        end
    end

    // Blocks a false edge on the first cycle after reset
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            primed_q <= 1'b0;
        end else begin
            primed_q <= 1'b1;
        end
    end

    // Edge selection per comparator
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            case (ctrl_q[i][acs_pkg::ACS_CTRL_SENS_LSB +: 2])
                acs_pkg::ACS_SENS_TOGGLE: begin
                    edge_evt[i] = cmp_level_in[i] ^ level_prev_q[i];
                end
                acs_pkg::ACS_SENS_FALL: begin
                    edge_evt[i] = ~cmp_level_in[i] & level_prev_q[i];
                end
                acs_pkg::ACS_SENS_RISE: begin
                    edge_evt[i] = cmp_level_in[i] & ~level_prev_q[i];
                end
                default: begin
                    edge_evt[i] = 1'b0;
                end
            endcase
            edge_evt[i] = edge_evt[i] & primed_q;
        end
    end

    // Flag clear sources
    always_comb begin
        wr_clr = 3'h0;
        if (wr_status) begin
            wr_clr = bus_req.wdata[acs_pkg::ACS_STAT_FLAG_LSB +: 3];
        end
        vec_clr = cmp_vector_taken & ie_vec;
    end

    // Event flags; a new event wins over a clear in the same cycle
    assign flag_d = (flag_q & ~(wr_clr | vec_clr)) | edge_evt;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            flag_q <= acs_pkg::ACS_RST_TRIO;
        end else begin
            flag_q <= flag_d;
        end
    end

    // Per-comparator requests and conversion triggers
    assign cmp_irq_req = flag_q & ie_vec;
    assign cmp_trigger = flag_q;

    // Comparator control registers
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 3; i++) begin
                ctrl_q[i] <= acs_pkg::ACS_RST_BYTE;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (wr_ctrl[i]) begin
                    ctrl_q[i] <= bus_req.wdata & acs_pkg::ACS_CTRL_MASK;
                end
            end
        end
    end

    // Hysteresis decode to analog drive
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 3; i++) begin
                hyst_drive[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                hyst_drive[i].code <=
                    ctrl_q[i][acs_pkg::ACS_CTRL_HYST_LSB +: 3];
                case (ctrl_q[i][acs_pkg::ACS_CTRL_HYST_LSB +: 3])
                    3'h1: begin
                        hyst_drive[i].pos_en <= 1'b1;
                        hyst_drive[i].neg_en <= 1'b0;
                        hyst_drive[i].large_step <= 1'b0;
                    end
                    3'h2: begin
                        hyst_drive[i].pos_en <= 1'b0;
                        hyst_drive[i].neg_en <= 1'b1;
                        hyst_drive[i].large_step <= 1'b0;
                    end
                    3'h3: begin
                        hyst_drive[i].pos_en <= 1'b1;
                        hyst_drive[i].neg_en <= 1'b1;
                        hyst_drive[i].large_step <= 1'b0;
                    end
                    3'h5: begin
                        hyst_drive[i].pos_en <= 1'b1;
                        hyst_drive[i].neg_en <= 1'b0;
                        hyst_drive[i].large_step <= 1'b1;
                    end
                    3'h6: begin
                        hyst_drive[i].pos_en <= 1'b0;
                        hyst_drive[i].neg_en <= 1'b1;
                        hyst_drive[i].large_step <= 1'b1;
                    end
                    3'h7: begin
                        hyst_drive[i].pos_en <= 1'b1;
                        hyst_drive[i].neg_en <= 1'b1;
                        hyst_drive[i].large_step <= 1'b1;
                    end
                    default: begin
                        // None, and the reserved code, give no hysteresis
                        hyst_drive[i].pos_en <= 1'b0;
                        hyst_drive[i].neg_en <= 1'b0;
                        hyst_drive[i].large_step <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Input-disable register for pins 7..0
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dis0_q <= acs_pkg::ACS_RST_BYTE;
        end else if (wr_dis0) begin
            dis0_q <= bus_req.wdata;
        end
    end

    // Input-disable register for pins 13..8; bits 7..6 stay zero
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            dis1_q <= acs_pkg::ACS_RST_BYTE;
        end else if (wr_dis1) begin
            dis1_q <= bus_req.wdata & acs_pkg::ACS_DIS1_MASK;
        end
    end

    // Buffer gating and forced-low pin reads
    assign dis_all = {dis1_q[5:0], dis0_q};

    // Buffer enables follow the disable bits one cycle later
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pin_buf_off <= acs_pkg::ACS_RST_PINS;
        end else begin
            pin_buf_off <= dis_all;
        end
    end

    // Pin reads, forced low where the buffer is off
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pin_read <= acs_pkg::ACS_RST_PINS;
        end else begin
            pin_read <= pin_raw & ~dis_all;
        end
    end

    // Block interrupt: sticky on each new flag event
    always_comb begin
        irq_clr = 3'h0;
        if (wr_irq_clr) begin
            irq_clr = bus_req.wdata[2:0];
        end
    end

    // Sticky block status; a new event wins over a clear
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irq_stat_q <= acs_pkg::ACS_RST_TRIO;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | edge_evt;
        end
    end

    // Block interrupt enables
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            irq_en_q <= acs_pkg::ACS_RST_TRIO;
        end else if (wr_irq_en) begin
            irq_en_q <= bus_req.wdata[2:0];
        end
    end

    assign irq = |(irq_stat_q & irq_en_q);

    // Status byte view; levels read straight from the comparators
    always_comb begin
        status_view = 8'h00;
        status_view[acs_pkg::ACS_STAT_FLAG_LSB +: 3] = flag_q;
        status_view[acs_pkg::ACS_STAT_LEVEL_LSB +: 3] = cmp_level_in;
    end

    // Read decode; unmapped and write-only offsets read zero
    always_comb begin
        rdata_d = 8'h00;
        if (bus_req.rd) begin
            if (bus_req.addr == acs_pkg::ACS_OFF_STATUS) begin
                rdata_d = status_view;
            end else if (bus_req.addr == acs_pkg::ACS_OFF_DIS0) begin
                rdata_d = dis0_q;
            end else if (bus_req.addr == acs_pkg::ACS_OFF_DIS1) begin
                rdata_d = dis1_q;
            end else if (bus_req.addr == acs_pkg::ACS_OFF_CTRL1) begin
                rdata_d = ctrl_q[0];
            end else if (bus_req.addr == acs_pkg::ACS_OFF_CTRL2) begin
                rdata_d = ctrl_q[1];
            end else if (bus_req.addr == acs_pkg::ACS_OFF_CTRL3) begin
                rdata_d = ctrl_q[2];
            end else if (bus_req.addr == acs_pkg::ACS_OFF_IRQ_STAT) begin
                rdata_d = {5'h00, irq_stat_q};
            end else if (bus_req.addr == acs_pkg::ACS_OFF_IRQ_EN) begin
                rdata_d = {5'h00, irq_en_q};
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rdata_q <= acs_pkg::ACS_RST_BYTE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign bus_rdata = rdata_q;

endmodule : acs_status

// >>> verification/acs_cmp_model.sv
// Behavioural comparators and interrupt vector unit facing the bank.
// Assumes level commands and answer enables come from the bench.
`timescale 1ns/100ps
module acs_cmp_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [2:0] lvl_cmd,
    input wire logic [2:0] ack_en,
    input wire logic [2:0] force_take,
    input wire logic [2:0] cmp_irq_req,
    output logic [2:0] cmp_level_in,
    output logic [2:0] cmp_vector_taken
);
    // Outputs follow the bench; one vector pulse per request
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cmp_level_in <= 3'h0;
            cmp_vector_taken <= 3'h0;
        end else begin
            cmp_level_in <= lvl_cmd;
            cmp_vector_taken <= force_take
                | (ack_en & cmp_irq_req & ~cmp_vector_taken);
        end
    end
endmodule : acs_cmp_model

// >>> verification/acs_status_props.sv
// Port-level checker for the comparator status bank.
// Assumes it is bound to every instance of acs_status.
`timescale 1ns/100ps
module acs_status_props (
    input wire logic ref_clk,
    input wire logic reset,
    input wire acs_pkg::acs_bus_req_t bus_req,
    input wire logic [7:0] bus_rdata,
    input wire logic [2:0] cmp_level_in,
    input wire logic [2:0] cmp_vector_taken,
    input wire logic [2:0] cmp_irq_req,
    input wire logic [2:0] cmp_trigger,
    input wire acs_pkg::acs_hyst_t [2:0] hyst_drive,
    input wire logic [13:0] pin_raw,
    input wire logic [13:0] pin_read,
    input wire logic [13:0] pin_buf_off,
    input wire logic irq
);
    acs_pkg::acs_hyst_t h0;
    // Comparator 1 drive under watch
    assign h0 = hyst_drive[0];
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_rd_stat;
        $past(bus_req.rd) && $past(bus_req.addr) == acs_pkg::ACS_OFF_STATUS;
    endsequence
    a_stat_flags: assert property (
        s_rd_stat |-> bus_rdata[7:5] == $past(cmp_trigger))
        else $error("status flags differ from triggers");
    a_stat_level: assert property (
        s_rd_stat |-> bus_rdata[3:1] == $past(cmp_level_in))
        else $error("status levels differ from inputs");
    a_stat_rsvd: assert property (
        s_rd_stat |-> bus_rdata[4] == 1'b0 && bus_rdata[0] == 1'b0)
        else $error("reserved status bit set");
    a_irq_gate: assert property (
        (cmp_irq_req & ~cmp_trigger) == 3'h0)
        else $error("request without flag");
    a_vec_clear: assert property (
        cmp_vector_taken[0] && cmp_irq_req[0] && $stable(cmp_level_in[0])
        |=> !cmp_trigger[0])
        else $error("flag kept after vector entry");
    a_vec_noen: assert property (
        cmp_vector_taken[2] && !cmp_irq_req[2] && cmp_trigger[2]
        && !bus_req.wr && $stable(cmp_level_in[2]) |=> cmp_trigger[2])
        else $error("flag lost on vector without enable");
    a_flag_cause: assert property (
        $rose(cmp_trigger[0]) |->
        $past(cmp_level_in[0]) != $past(cmp_level_in[0], 2))
        else $error("flag set without output edge");
    a_flag_wclr: assert property (
        bus_req.wr && bus_req.addr == acs_pkg::ACS_OFF_STATUS
        && !cmp_vector_taken[0] && $stable(cmp_level_in[0]) |=>
        cmp_trigger[0] == ($past(cmp_trigger[0]) && !$past(bus_req.wdata[5])))
        else $error("flag write effect wrong");
    a_pin_gate: assert property (
        $stable(pin_buf_off) && pin_buf_off == $past(pin_buf_off, 2)
        |-> pin_read == ($past(pin_raw) & ~pin_buf_off))
        else $error("disabled pin reads nonzero");
    a_hyst_code: assert property (
        h0.pos_en == h0.code[0] && h0.neg_en == h0.code[1]
        && h0.large_step == (h0.code[2] && h0.code[1:0] != 2'h0))
        else $error("hysteresis decode wrong");
    c_rd_flag: cover property (s_rd_stat ##0 bus_rdata[7:5] != 3'h0);
    c_vec: cover property (cmp_vector_taken[0] && cmp_irq_req[0]);
    c_irq: cover property ($rose(irq));
endmodule : acs_status_props

bind acs_status acs_status_props u_props (.ref_clk(ref_clk), .reset(reset),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .cmp_level_in(cmp_level_in),
    .cmp_vector_taken(cmp_vector_taken), .cmp_irq_req(cmp_irq_req),
    .cmp_trigger(cmp_trigger), .hyst_drive(hyst_drive), .pin_raw(pin_raw),
    .pin_read(pin_read), .pin_buf_off(pin_buf_off), .irq(irq));

// >>> verification/tb_acs_status.sv
// Self-checking bench for the comparator status bank.
// Assumes the comparator and vector model of acs_cmp_model.
`timescale 1ns/100ps
module tb_acs_status;
    logic ref_clk;
    logic reset = 1'b1;
    acs_pkg::acs_bus_req_t bus_req = '0;
    acs_pkg::acs_hyst_t [2:0] hyd;
    logic [7:0] bus_rdata;
    logic [2:0] lvl, vtk, req, trig;
    logic [2:0] lc = 3'h0, ack = 3'h0, frc = 3'h0;
    logic [13:0] praw = 14'h0000, prd, poff;
    logic irq;
    int fails = 0, n_tests = 0;
    logic [31:0] rnd = 32'h7a9b4f4d;
    logic [7:0] m_ctl [3] = '{default: 8'h00};
    logic [7:0] m_d0 = 8'h00, m_d1 = 8'h00, m_ien = 8'h00;
    logic [2:0] m_lvl = 3'h0, m_flag = 3'h0, m_stat = 3'h0;
    acs_status i_acs_status (.ref_clk(ref_clk), .reset(reset),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .cmp_level_in(lvl),
        .cmp_vector_taken(vtk), .cmp_irq_req(req), .cmp_trigger(trig),
        .hyst_drive(hyd), .pin_raw(praw), .pin_read(prd),
        .pin_buf_off(poff), .irq(irq));
    acs_cmp_model i_model (.ref_clk(ref_clk), .reset(reset), .lvl_cmd(lc),
        .ack_en(ack), .force_take(frc), .cmp_irq_req(req),
        .cmp_level_in(lvl), .cmp_vector_taken(vtk));
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [7:0] ex(logic [7:0] a);
        case (a)
            8'h00: return {m_flag, 1'b0, m_lvl, 1'b0};
            8'h01: return m_d0;
            8'h02: return m_d1;
            8'h03, 8'h04, 8'h05: return m_ctl[a - 8'h03];
            8'h06: return {5'h00, m_stat};
            8'h08: return m_ien;
            default: return 8'h00;
        endcase
    endfunction : ex
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Register write, mirrored in the model
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge ref_clk) bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk) bus_req.wr <= 1'b0;
        case (a)
            8'h00: m_flag &= ~d[7:5];
            8'h01: m_d0 = d;
            8'h02: m_d1 = d & 8'h3f;
            8'h03, 8'h04, 8'h05: m_ctl[a - 8'h03] = d & 8'h77;
            8'h07: m_stat &= ~d[2:0];
            8'h08: m_ien = d & 8'h07;
            default: ;
        endcase
    endtask : wr
    // Register read compared with the model
    task automatic rc(logic [7:0] a);
        @(posedge ref_clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk) bus_req.rd <= 1'b0;
        #1 chk(bus_rdata, ex(a));
    endtask : rc
    // New comparator levels; vector entries clear enabled flags
    task automatic lv(logic [2:0] v);
        logic [1:0] s;
        for (int n = 0; n < 3; n++) begin
            s = m_ctl[n][5:4];
            if (v[n] != m_lvl[n] && (s == 2'h0 || s == {1'b1, v[n]})) begin
                m_flag[n] = 1'b1;
                m_stat[n] = 1'b1;
            end
        end
        m_lvl = v;
        @(posedge ref_clk) lc <= v;
        repeat (6) @(posedge ref_clk);
        m_flag &= ~(ack & {m_ctl[2][6], m_ctl[1][6], m_ctl[0][6]});
    endtask : lv
    task automatic look();
        rc(8'h00);
        rc(8'h06);
        chk(trig, m_flag);
        chk(req, m_flag & {m_ctl[2][6], m_ctl[1][6], m_ctl[0][6]});
        chk(irq, |(m_stat & m_ien[2:0]));
    endtask : look
    // Watchdog
    initial begin
        #200000;
        fails++;
        stop_test();
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        for (int a = 0; a < 10; a++) rc(a[7:0]);
        rc(8'hff);
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            wr(8'(3 + i % 3), {rnd[7:3], i[2:0]});
            wr(8'h01, rnd[15:8]);
            wr(8'h02, rnd[23:16]);
            praw <= rnd[29:16];
            repeat (2) @(posedge ref_clk);
            #1 chk(hyd[i % 3], {i[2:0], i[0], i[1], i[2] & |i[1:0]});
            chk(poff, {m_d1[5:0], m_d0});
            chk(prd, praw & ~{m_d1[5:0], m_d0});
            rc(8'(3 + i % 3));
            rc(8'h02);
        end
        wr(8'h08, 8'h05);
        for (int s = 0; s < 4; s++) begin
            for (int n = 0; n < 3; n++) wr(8'(3 + n), {2'h0, s[1:0], 4'h3});
            lv(3'h5);
            look();
            lv(3'h0);
            look();
            lv(3'h7);
            look();
            wr(8'h00, 8'h5f);
            look();
            wr(8'h00, 8'hff);
            wr(8'h07, 8'h07);
            look();
        end
        for (int n = 0; n < 3; n++) wr(8'(3 + n), 8'h70);
        ack <= 3'h3;
        lv(3'h0);
        lv(3'h7);
        look();
        wr(8'h05, 8'h30);
        @(posedge ref_clk) frc <= 3'h4;
        @(posedge ref_clk) frc <= 3'h0;
        lv(3'h7);
        look();
        stop_test();
    end
endmodule : tb_acs_status
